// >>> disk_host_port.sv
// Host bus port of the disk controller: decode, data lanes, sector buffer, interrupt
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// R1: Low data byte carries sector data and all command, control, status bytes.
// R2: High data byte is used only for sector data transfers.
// R3: No port response while the DMA controller owns the bus.
// R4: Host supplies a 10-bit port address; decode uses exactly ten bits.
// R5: Bus reset returns the whole port to its power-up state.
// R6: Write strobe to a selected port captures the host data byte.
// R7: Read strobe to a selected port drives data; lines released otherwise.
// R8: Address latch strobe captures the address used for port selection.
// R9: Data port selection asserts the wide-cycle select line.
// R10: Interrupt request asserted whenever host service is needed.
// R11: Each word splits across two byte-wide RAMs, one per lane.
// R12: Sector buffer never holds more than one 512-byte sector.
// R13: Sector data moves as 16-bit words; control and status stay 8-bit.
// R14: Selectable base lets two identical boards share one host.
// R15: Interrupt stays asserted until the host reads the status port.
module disk_host_port
  import host_port_pkg::*;
#(
  parameter int RAM_DEPTH = 2048
) (
  // Clock and reset
  input  wire logic                               mclk,
  input  wire logic                               rst,
  // Host address and control pins
  input  wire logic [host_port_pkg::ADDR_W-1:0]   port_address,
  input  wire logic                               address_latch_strobe,
  input  wire logic                               dma_owns_bus,
  input  wire logic                               port_read_strobe,
  input  wire logic                               port_write_strobe,
  input  wire logic                               board_secondary,
  // Host data lanes, each as in, out and active-low enable
  input  wire logic [7:0]                         low_byte_in,
  output logic      [7:0]                         low_byte_out,
  output logic                                    low_byte_oe_n,
  input  wire logic [7:0]                         high_byte_in,
  output logic      [7:0]                         high_byte_out,
  output logic                                    high_byte_oe_n,
  // Host signals driven by the board
  output logic                                    wide_cycle_select,
  output logic                                    host_interrupt_request,
  // Internal controller side
  output logic      [7:0]                         command_byte,
  output logic                                    command_strobe,
  input  wire logic                               service_request,
  input  wire logic                               busy
);
  import host_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  // One shared synchroniser keeps address, strobes and data aligned in time
  // Four clocks from pin to use; the host holds each phase for five clocks or more
  localparam int NSYNC = ADDR_W + 21;
  logic [NSYNC-1:0] sync_raw;
  logic [NSYNC-1:0] sync_lvl;
  assign sync_raw = {port_address, address_latch_strobe, dma_owns_bus, port_read_strobe,
                     port_write_strobe, board_secondary, low_byte_in, high_byte_in};

  pin_sync #(.W(NSYNC), .RST_VAL('0)) u_sync (
    .mclk      (mclk),
    .rst       (rst),
    .pin_in    (sync_raw),
    .level_out (sync_lvl)
  );

  logic [ADDR_W-1:0] addr_s;
  logic              ale_s;
  logic              dma_s;
  logic              rd_s;
  logic              wr_s;
  logic              sec_s;
  logic [7:0]        lo_s;
  logic [7:0]        hi_s;
  assign addr_s = sync_lvl[NSYNC-1 -: ADDR_W];
  assign ale_s  = sync_lvl[20];
  assign dma_s  = sync_lvl[19];
  assign rd_s   = sync_lvl[18];
  assign wr_s   = sync_lvl[17];
  assign sec_s  = sync_lvl[16];
  assign lo_s   = sync_lvl[15:8];
  assign hi_s   = sync_lvl[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Address latch and decode
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              rd_prev_q, wr_prev_q;
  logic [9:0]        base;
  logic              sel_any, sel_data, sel_stat;
  logic              rd_rise, wr_rise;

  always_comb
  begin
    addr_d = addr_q;
    if (ale_s)
      addr_d = addr_s; // R8 R4
  end

  // R14
  assign base     = sec_s ? BASE_SECONDARY : BASE_PRIMARY;
  assign sel_any  = !dma_s && (addr_q[9:3] == base[9:3]); // R3 R4
  // Offsets other than data and command/status stay unanswered
  assign sel_data = sel_any && (addr_q[2:0] == OFS_DATA);
  assign sel_stat = sel_any && (addr_q[2:0] == OFS_CMD_STATUS);
  assign rd_rise  = rd_s && !rd_prev_q;
  assign wr_rise  = wr_s && !wr_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sector buffer: two byte-wide lanes
  localparam int RAW = $clog2(RAM_DEPTH);
  logic [7:0] ram_lo [RAM_DEPTH];
  logic [7:0] ram_hi [RAM_DEPTH];
  logic [8:0] ptr_q, ptr_d;
  logic       full_q, full_d;
  logic       ram_we;
  logic [RAW-1:0] ram_idx;

  // R12: index never leaves the first 256 words
  assign ram_idx = RAW'(ptr_q[7:0]);
  assign ram_we  = wr_rise && sel_data && !full_q;

  always_ff @(posedge mclk)
  begin
    if (ram_we)
    begin
      ram_lo[ram_idx] <= lo_s; // R11
      ram_hi[ram_idx] <= hi_s; // R11 R13
    end
  end

  always_comb
  begin
    ptr_d  = ptr_q;
    full_d = full_q;
    // Writes into a full buffer are dropped but still move the pointer
    if ((wr_rise || rd_rise) && sel_data)
    begin
      if (ptr_q == 9'(SECTOR_WORDS - 1))
      begin
        ptr_d  = PTR_RESET_VAL; // R12
        full_d = wr_rise;
      end
      else
        ptr_d = ptr_q + 9'h001;
    end
    if (wr_rise && sel_stat)
    begin
      ptr_d  = PTR_RESET_VAL;
      full_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command, interrupt and host-facing outputs
  logic [7:0] cmd_q, cmd_d;
  logic       cstb_q, cstb_d;
  logic       irq_q, irq_d;
  logic [7:0] lo_out_q, lo_out_d, hi_out_q, hi_out_d;
  logic       lo_oe_n_q, lo_oe_n_d, hi_oe_n_q, hi_oe_n_d;
  logic       wide_q, wide_d;
  logic [7:0] status;

  assign status = {busy, 3'b000, full_q, 1'b0, irq_q, 1'b0};

  always_comb
  begin
    cmd_d  = cmd_q;
    cstb_d = 1'b0;
    irq_d  = irq_q;
    if (wr_rise && sel_stat)
    begin
      cmd_d  = lo_s; // R6 R1
      cstb_d = 1'b1;
    end
    if (rd_rise && sel_stat)
      irq_d = 1'b0; // R15
    // Set after clear so a request in the acknowledge cycle is kept
    if (service_request)
      irq_d = 1'b1; // R10
    lo_out_d  = 8'h00;
    hi_out_d  = 8'h00;
    lo_oe_n_d = 1'b1;
    hi_oe_n_d = 1'b1;
    // Value taken once at the strobe edge and held: the pointer moves on
    // that edge and status may change while the host still reads
    if (rd_s && sel_data)
    begin
      lo_out_d  = rd_rise ? ram_lo[ram_idx] : lo_out_q; // R7 R13
      hi_out_d  = rd_rise ? ram_hi[ram_idx] : hi_out_q; // R2
      lo_oe_n_d = 1'b0;
      hi_oe_n_d = 1'b0;
    end
    else if (rd_s && sel_stat)
    begin
      lo_out_d  = rd_rise ? status : lo_out_q; // R1 R7
      lo_oe_n_d = 1'b0;
    end
    wide_d = sel_data; // R9
  end

  always_ff @(posedge mclk)
  begin
    if (rst) // R5
    begin
      addr_q    <= '0;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      ptr_q     <= PTR_RESET_VAL;
      full_q    <= 1'b0;
      cmd_q     <= CMD_RESET_VAL;
      cstb_q    <= 1'b0;
      irq_q     <= 1'b0;
      lo_out_q  <= 8'h00;
      hi_out_q  <= 8'h00;
      lo_oe_n_q <= 1'b1;
      hi_oe_n_q <= 1'b1;
      wide_q    <= 1'b0;
    end
    else
    begin
      addr_q    <= addr_d;
      rd_prev_q <= rd_s;
      wr_prev_q <= wr_s;
      ptr_q     <= ptr_d;
      full_q    <= full_d;
      cmd_q     <= cmd_d;
      cstb_q    <= cstb_d;
      irq_q     <= irq_d;
      lo_out_q  <= lo_out_d;
      hi_out_q  <= hi_out_d;
      lo_oe_n_q <= lo_oe_n_d;
      hi_oe_n_q <= hi_oe_n_d;
      wide_q    <= wide_d;
    end
  end

  assign low_byte_out           = lo_out_q;
  assign high_byte_out          = hi_out_q;
  assign low_byte_oe_n          = lo_oe_n_q;
  assign high_byte_oe_n         = hi_oe_n_q;
  assign wide_cycle_select      = wide_q;
  assign host_interrupt_request = irq_q;
  assign command_byte           = cmd_q;
  assign command_strobe         = cstb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_HIGH_LANE_DATA_ONLY: assert property (!hi_oe_n_q |-> $past(sel_data)) // R2
    else $error("high lane driven outside a data read");
  AST_NO_DMA_RESPONSE: assert property (dma_s |=> (lo_oe_n_q && !wide_q)) // R3
    else $error("port answered while dma owns bus");
  AST_RESET_STATE: assert property ($past(rst) |-> (!irq_q && lo_oe_n_q && ptr_q == 9'h000)) // R5
    else $error("reset state not reached");
  AST_CMD_CAPTURE: assert property ((wr_rise && sel_stat) |=> (cstb_q && cmd_q == $past(lo_s))) // R6
    else $error("command byte not captured");
  AST_READ_DRIVE: assert property ((rd_s && sel_stat) |=> !lo_oe_n_q) // R7
    else $error("status read not driven");
  AST_RELEASE: assert property (!rd_s |=> (lo_oe_n_q && hi_oe_n_q)) // R7
    else $error("lines not released");
  AST_WIDE_SELECT: assert property (sel_data |=> wide_q) // R9
    else $error("wide cycle select missing");
  AST_IRQ_SET: assert property (service_request |=> irq_q) // R10
    else $error("interrupt not raised");
  AST_IRQ_HOLD: assert property ((irq_q && !(rd_rise && sel_stat)) |=> irq_q) // R15
    else $error("interrupt dropped without status read");
  AST_SECTOR_LIMIT: assert property (ptr_q < 9'(SECTOR_WORDS)) // R12
    else $error("buffer pointer beyond one sector");

  // Host-visible handshake, address latch and command capture
  AST_READ_STABLE: assert property ((rd_s && !rd_rise && (sel_data || sel_stat)) |=> $stable(lo_out_q)) // R7
    else $error("read data changed during strobe");
  AST_DATA_LANES: assert property ((rd_s && sel_data) |=> (!lo_oe_n_q && !hi_oe_n_q)) // R13
    else $error("data read not driven on both lanes");
  AST_STATUS_LOW_ONLY: assert property ((rd_s && sel_stat) |=> hi_oe_n_q) // R2
    else $error("high lane driven on status read");
  AST_WIDE_DROP: assert property (!sel_data |=> !wide_q) // R9
    else $error("wide cycle select outside data port");
  AST_ADDR_LATCH: assert property (ale_s |=> (addr_q == $past(addr_s))) // R8
    else $error("address not latched");
  AST_DMA_NO_WRITE: assert property (dma_s |-> !ram_we) // R3
    else $error("buffer written during dma cycle");
  AST_CSTB_PULSE: assert property (cstb_q |=> !cstb_q) // R6
    else $error("command strobe longer than one cycle");
  AST_CMD_HOLD: assert property (!(wr_rise && sel_stat) |=> $stable(cmd_q)) // R6
    else $error("command byte changed without a write");

  // Buffer and interrupt bookkeeping
  AST_WRAP_FULL: assert property ((wr_rise && sel_data && ptr_q == 9'(SECTOR_WORDS - 1)) |=> full_q) // R12
    else $error("buffer not full after one sector");
  AST_READ_EMPTIES: assert property ((rd_rise && sel_data && ptr_q == 9'(SECTOR_WORDS - 1)) |=> !full_q) // R12
    else $error("buffer still full after sector read");
  AST_STATUS_WRITE_CLEARS: assert property ((wr_rise && sel_stat) |=> (!full_q && ptr_q == 9'h000)) // R12
    else $error("command write did not rewind buffer");
  AST_IRQ_CLEAR: assert property ((rd_rise && sel_stat && !service_request) |=> !irq_q) // R15
    else $error("interrupt kept after status read");

  // Main scenarios
  COV_DATA_WRITE: cover property (ram_we);
  COV_FULL: cover property (full_q);
  COV_IRQ_ACK: cover property (irq_q ##1 !irq_q);
  COV_DATA_READ: cover property (rd_rise && sel_data);
  COV_DMA_REFUSED: cover property (dma_s && (rd_rise || wr_rise));
endmodule : disk_host_port
`default_nettype wire

// >>> host_port_pkg.sv
// Constants shared by the disk controller host port
`default_nettype none
package host_port_pkg;
  localparam int          ADDR_W          = 10;
  localparam int          BUF_AW          = 11;
  localparam int          SECTOR_WORDS    = 256;
  localparam logic [9:0]  BASE_PRIMARY    = 10'h1F0;
  localparam logic [9:0]  BASE_SECONDARY  = 10'h170;
  localparam logic [2:0]  OFS_DATA        = 3'h0;
  localparam logic [2:0]  OFS_CMD_STATUS  = 3'h7;
  localparam logic [7:0]  CMD_RESET_VAL   = 8'h00;
  localparam logic [7:0]  STATUS_RESET_VAL = 8'h00;
  localparam logic [8:0]  PTR_RESET_VAL   = 9'h000;
  localparam int          STATUS_BUF_FULL_BIT = 3;
  localparam int          STATUS_IRQ_BIT  = 1;
  localparam int          STATUS_BUSY_BIT = 7;
endpackage : host_port_pkg
`default_nettype wire

// >>> pin_sync.sv
// Three-flop input synchroniser with agreement filter
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Raw and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;
  logic [W-1:0] level_q;

  // Change accepted only when second and third stages agree
  always_comb
  begin
    level_d = level_q;
    for (int i = 0; i < W; i++)
    begin
      if (s2_q[i] == s3_q[i])
        level_d[i] = s2_q[i];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      level_q <= RST_VAL;
    end
    else
    begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule : pin_sync
`default_nettype wire

// >>> host_cpu_model.sv
// Host processor model: address phase, strobes and resolved data lanes
`default_nettype none
module host_cpu_model
(
  // Clock
  input  wire logic       mclk,
  // Address and strobes
  output logic [9:0]      port_address,
  output logic            address_latch_strobe,
  output logic            port_read_strobe,
  output logic            port_write_strobe,
  // Data lanes, resolved from both parties
  output logic [7:0]      low_byte_in,
  output logic [7:0]      high_byte_in,
  input  wire logic [7:0] low_byte_out,
  input  wire logic [7:0] high_byte_out,
  input  wire logic       low_byte_oe_n,
  input  wire logic       high_byte_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_d, hi_d, lo_last, hi_last;
  logic       drv;
  // Released lanes toggle so stale data never passes as an answer
  assign low_byte_in  = drv ? lo_d : (!low_byte_oe_n ? low_byte_out : ~lo_last);
  assign high_byte_in = drv ? hi_d : (!high_byte_oe_n ? high_byte_out : ~hi_last);
  initial
  begin
    {port_address, address_latch_strobe, port_read_strobe, port_write_strobe} = '0;
    {lo_d, hi_d, lo_last, hi_last, drv} = '0;
  end
  always @(posedge mclk)
  begin
    lo_last <= low_byte_in;
    hi_last <= high_byte_in;
  end
  // Returns {high_oe_n, low_oe_n, high lane, low lane} seen at the end of the strobe
  task automatic access(input logic [9:0] a, input logic w, input logic [15:0] wd,
                        output logic [17:0] rd);
    @(posedge mclk);
    port_address         <= a;
    address_latch_strobe <= 1'b1;
    repeat (5) @(posedge mclk);
    address_latch_strobe <= 1'b0;
    lo_d                 <= wd[7:0];
    hi_d                 <= wd[15:8];
    drv                  <= w;
    port_write_strobe    <= w;
    port_read_strobe     <= !w;
    repeat (6) @(posedge mclk);
    rd = {high_byte_oe_n, low_byte_oe_n, high_byte_in, low_byte_in};
    drv                  <= 1'b0;
    port_write_strobe    <= 1'b0;
    port_read_strobe     <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : access
endmodule : host_cpu_model
`default_nettype wire

// >>> disk_controller_host_port_tb.sv
// Self-checking bench for the disk controller host port
`default_nettype none
module disk_controller_host_port_tb;
  import host_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] P_DATA = {BASE_PRIMARY[9:3], OFS_DATA};
  localparam logic [9:0] P_CMD  = {BASE_PRIMARY[9:3], OFS_CMD_STATUS};
  localparam logic [9:0] S_CMD  = {BASE_SECONDARY[9:3], OFS_CMD_STATUS};
  logic        mclk, rst, dma_owns_bus, board_secondary, service_request, busy;
  logic [9:0]  port_address;
  logic        address_latch_strobe, port_read_strobe, port_write_strobe;
  logic [7:0]  low_byte_in, low_byte_out, high_byte_in, high_byte_out, command_byte;
  logic        low_byte_oe_n, high_byte_oe_n, wide_cycle_select, host_interrupt_request, command_strobe;
  logic [17:0] rd;
  int          fail_count, samples_checked, cmd_count, cycles;
  disk_host_port i_dut (.mclk(mclk), .rst(rst), .port_address(port_address),
    .address_latch_strobe(address_latch_strobe), .dma_owns_bus(dma_owns_bus),
    .port_read_strobe(port_read_strobe), .port_write_strobe(port_write_strobe),
    .board_secondary(board_secondary), .low_byte_in(low_byte_in), .low_byte_out(low_byte_out),
    .low_byte_oe_n(low_byte_oe_n), .high_byte_in(high_byte_in), .high_byte_out(high_byte_out),
    .high_byte_oe_n(high_byte_oe_n), .wide_cycle_select(wide_cycle_select),
    .host_interrupt_request(host_interrupt_request), .command_byte(command_byte),
    .command_strobe(command_strobe), .service_request(service_request), .busy(busy));
  host_cpu_model i_host (.mclk(mclk), .port_address(port_address),
    .address_latch_strobe(address_latch_strobe), .port_read_strobe(port_read_strobe),
    .port_write_strobe(port_write_strobe), .low_byte_in(low_byte_in), .high_byte_in(high_byte_in),
    .low_byte_out(low_byte_out), .high_byte_out(high_byte_out), .low_byte_oe_n(low_byte_oe_n),
    .high_byte_oe_n(high_byte_oe_n));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (command_strobe === 1'b1) cmd_count <= cmd_count + 1;
    if (cycles == 20000)
    begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    chk({low_byte_out, high_byte_out}, 0);
    chk(command_byte, 0);
    chk({low_byte_oe_n, high_byte_oe_n, wide_cycle_select, host_interrupt_request, command_strobe}, 5'b11000);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : do_reset
  task automatic test_command();
    int n;
    n = cmd_count;
    i_host.access(P_CMD, 1'b1, 16'h00A5, rd);
    chk(cmd_count - n, 1);
    chk(command_byte, 8'hA5);
    dma_owns_bus <= 1'b1;
    i_host.access(P_CMD, 1'b1, 16'h005A, rd);
    dma_owns_bus <= 1'b0;
    chk(cmd_count - n, 1);
    board_secondary <= 1'b1;
    i_host.access(P_CMD, 1'b1, 16'h003C, rd);
    chk(cmd_count - n, 1);
    i_host.access(S_CMD, 1'b1, 16'h00C3, rd);
    chk(cmd_count - n, 2);
    chk(command_byte, 8'hC3);
    board_secondary <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : test_command
  task automatic test_irq();
    busy            <= 1'b1;
    service_request <= 1'b1;
    @(posedge mclk);
    service_request <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(host_interrupt_request, 1);
    i_host.access(P_CMD, 1'b0, 16'h0000, rd);
    chk(rd[17:16], 2'b10);
    chk(rd[7:0], 8'h82);
    repeat (4) @(posedge mclk);
    chk(host_interrupt_request, 0);
    busy            <= 1'b0;
    service_request <= 1'b1;
    @(posedge mclk);
    service_request <= 1'b0;
    repeat (8) @(posedge mclk);
    do_reset();
  endtask : test_irq
  // High lane carries the index, low lane a scrambled copy
  function automatic logic [15:0] word(input int i);
    return {i[7:0], i[7:0] ^ 8'hC3};
  endfunction : word
  task automatic test_data();
    for (int i = 0; i < 256; i++) i_host.access(P_DATA, 1'b1, word(i), rd);
    chk(wide_cycle_select, 1);
    i_host.access(P_DATA, 1'b1, 16'hFFFE, rd);
    i_host.access(P_CMD, 1'b0, 16'h0000, rd);
    chk(rd[7:0], 8'h08);
    chk(wide_cycle_select, 0);
    i_host.access(P_CMD, 1'b1, 16'h0000, rd);
    for (int i = 0; i < 3; i++)
    begin
      i_host.access(P_DATA, 1'b0, 16'h0000, rd);
      chk(rd, {2'b00, word(i)});
    end
  endtask : test_data
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, dma_owns_bus, board_secondary, service_request, busy} = '0;
    {fail_count, samples_checked, cmd_count, cycles} = '0;
    do_reset();
    test_command();
    test_irq();
    test_data();
    end_sim();
  end
endmodule : disk_controller_host_port_tb
`default_nettype wire
